// File: logic/scs_defs.vh
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// register pointers
`define SCS_PTR_CFG1_RD   8'h03
`define SCS_PTR_CFG1_WR   8'h09
`define SCS_PTR_RATE_RD   8'h04
`define SCS_PTR_RATE_WR   8'h0a
`define SCS_PTR_CFG2      8'h1a
`define SCS_PTR_ONESHOT   8'h0f

// reset values
`define SCS_CFG1_RST      8'h00
`define SCS_CFG2_RST      8'h1c
`define SCS_RATE_RST      8'h07

// primary configuration fields
`define SCS_C1_MASK       7
`define SCS_C1_STOP       6
`define SCS_C1_PFS        5
`define SCS_C1_RANGE      2
`define SCS_C1_WMASK      8'he4

// secondary configuration fields
`define SCS_C2_REN        4
`define SCS_C2_LOCAL_ON   3
`define SCS_C2_RES_FIX    2
`define SCS_C2_WMASK      8'h1c

// timing in cycles of the 5 ns clock, sized to the counter so nothing is cut
`define SCS_CNT_W         20
`define SCS_CONV_CYC      20'd200 // 1000 ns conversion
`define SCS_CONV_HALF_CYC 20'd100 // remote conversion with correction off
`define SCS_IDLE_UNIT_CYC 20'd100 // 500 ns idle step per rate code

`endif

// File: logic/scs_cnt.v
`timescale 1ns/100ps
// down counter: loads a value, pulses done when it reaches one
module scs_cnt (
   input  wire                  clk_sys_i, // system clock
   input  wire                  rst_b_i,   // async reset, active low
   input  wire                  load_i,    // load pulse
   input  wire                  clr_i,     // abort count
   input  wire [19:0]           val_i,     // cycles to count
   output wire                  done_o,    // last cycle of count
   output wire                  busy_o     // count running
);
   reg [19:0] cnt_r;

   // count to zero; clr aborts a conversion at once on shutdown
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= 20'h00000;
      end else if (clr_i) begin
         cnt_r <= 20'h00000;
      end else if (load_i) begin
         cnt_r <= val_i;
      end else if (cnt_r != 20'h00000) begin
         cnt_r <= cnt_r - 20'h00001;
      end
   end

   assign busy_o = (cnt_r != 20'h00000);
   assign done_o = (cnt_r == 20'h00001);
endmodule // scs_cnt

// File: logic/scs_alarm.v
`timescale 1ns/100ps
// hysteresis comparator for one channel's over-high flag
module scs_alarm (
   input  wire                  clk_sys_i, // system clock
   input  wire                  rst_b_i,   // async reset, active low
   input  wire                  upd_i,     // result update pulse
   input  wire [7:0]            temp_i,    // new measurement
   input  wire [7:0]            lim_i,     // high limit
   input  wire [7:0]            hyst_i,    // shared hysteresis
   output reg                   hi_o       // over-high, hysteretic
);
   wire [8:0] thr_lo;
   // 9 bits so a large hysteresis cannot wrap below zero
   assign thr_lo = {1'b0, lim_i} - {1'b0, hyst_i};

   // set above limit, hold until at or below limit minus hysteresis
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hi_o <= 1'b0;
      end else if (upd_i) begin
         if (temp_i > lim_i) begin
            hi_o <= 1'b1;
         end else if (thr_lo[8] || ({1'b0, temp_i} <= thr_lo)) begin
            hi_o <= 1'b0;
         end
      end
   end
endmodule // scs_alarm

// File: logic/scs_seq.v
`timescale 1ns/100ps
`include "scs_defs.vh"
// Notes on behaviour
// - primary config written at pointer 09h, read back at 03h.
// - mask bit 0 drives alert low on fault; 1 keeps state, pin stays high.
// - in second overheat mode the mask bit is ignored.
// - stop bit 0 converts continuously; 1 halts at once, shutdown.
// - clearing stop bit resumes continuous conversions.
// - one-shot write in shutdown runs exactly one cycle: local then remote, enabled channels only.
// - pin function 0: pin is interrupt after consecutive faults.
// - pin function 1: pin low when local or remote over-high set.
// - config bit 2 selects standard or extended range.
// - primary config resets to 00h.
// - secondary config at 1Ah, resets to 1Ch.
// - secondary bit 2 enables series resistance fix; off halves remote time.
// - secondary bit 3 enables local channel.
// - secondary bit 4 enables remote channel.
// - sequence local, remote, shutdown, delay; disabled channels skipped.
// - rate register 0Ah sets idle delay only, not conversion time.
// - alert stays low until alert response transaction clears it.
// - remote over-high holds above limit minus hysteresis.
module scs_seq (
   input  wire                  clk_sys_i,    // system clock
   input  wire                  rst_b_i,      // async reset, active low
   input  wire                  wr_i,         // register write strobe
   input  wire [7:0]            ptr_i,        // register pointer
   input  wire [7:0]            wdata_i,      // write data
   output reg  [7:0]            rdata_o,      // read data, registered
   input  wire                  ara_i,        // alert response pulse
   input  wire [7:0]            local_temp_i, // local converter result
   input  wire [7:0]            remote_temp_i,// remote converter result
   input  wire [7:0]            local_hi_i,   // local high limit
   input  wire [7:0]            remote_hi_i,  // remote high limit
   input  wire [7:0]            hyst_i,       // shared hysteresis
   input  wire                  fault_i,      // limit fault, consecutive count met
   output reg                   conv_local_o, // local conversion active
   output reg                   conv_remote_o,// remote conversion active
   output wire                  busy_o,       // converter busy
   output wire                  upd_o,        // result update pulse
   output wire                  ext_range_o,  // extended range select
   output wire                  series_resistance_fix_o, // remote correction on
   output wire                  local_over_high_flag_o,  // local over-high
   output wire                  remote_over_high_flag_o, // remote over-high
   output wire                  shared_alarm_pin_o,      // pin output level
   output wire                  shared_alarm_pin_oe_o    // pin enable, low drives
);
   localparam ST_IDLE   = 3'd0;
   localparam ST_LOCAL  = 3'd1;
   localparam ST_REMOTE = 3'd2;
   localparam ST_SHUT   = 3'd3;
   localparam ST_DELAY  = 3'd4;

   reg  [7:0]  cfg1_r;
   reg  [7:0]  cfg2_r;
   reg  [7:0]  rate_r;
   reg  [2:0]  st_r;
   reg  [2:0]  st_nxt;
   reg         oneshot_r;
   reg         alert_r;
   reg         ch_local_r;
   reg         stop_q_r;
   wire        stop_rise;
   wire        stop_measure;
   wire        pin_function_select;
   wire        local_channel_on;
   wire        remote_on;
   wire        conv_busy;
   wire        conv_done;
   wire        idle_busy;
   wire        idle_done;
   reg         conv_load;
   reg         idle_load;
   reg  [19:0] conv_len;
   wire [19:0] idle_len;

   assign stop_measure        = cfg1_r[`SCS_C1_STOP];
   assign pin_function_select = cfg1_r[`SCS_C1_PFS];
   assign ext_range_o         = cfg1_r[`SCS_C1_RANGE];
   assign local_channel_on    = cfg2_r[`SCS_C2_LOCAL_ON];
   assign remote_on           = cfg2_r[`SCS_C2_REN];
   assign series_resistance_fix_o = cfg2_r[`SCS_C2_RES_FIX];
   // stop edge only: a one-shot runs with stop already high and must not abort
   assign stop_rise           = stop_measure && !stop_q_r;

   // register writes; reserved bits masked in case the host errs
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg1_r <= `SCS_CFG1_RST;
         cfg2_r <= `SCS_CFG2_RST;
         rate_r <= `SCS_RATE_RST;
      end else if (wr_i) begin
         if (ptr_i == `SCS_PTR_CFG1_WR) begin
            cfg1_r <= wdata_i & `SCS_C1_WMASK;
         end
         if (ptr_i == `SCS_PTR_CFG2) begin
            cfg2_r <= wdata_i & `SCS_C2_WMASK;
         end
         if (ptr_i == `SCS_PTR_RATE_WR) begin
            rate_r <= wdata_i;
         end
      end
   end

   // registered read mux; write-only pointers and unknown read zero
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
      end else begin
         case (ptr_i)
            `SCS_PTR_CFG1_RD: rdata_o <= cfg1_r;
            `SCS_PTR_CFG2:    rdata_o <= cfg2_r;
            `SCS_PTR_RATE_RD: rdata_o <= rate_r;
            default:          rdata_o <= 8'h00;
         endcase
      end
   end

   // one-shot request, held until a conversion cycle begins
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         oneshot_r <= 1'b0;
      end else if (wr_i && (ptr_i == `SCS_PTR_ONESHOT) && stop_measure) begin
         oneshot_r <= 1'b1;
      end else if (st_r == ST_IDLE && st_nxt != ST_IDLE) begin
         oneshot_r <= 1'b0;
      end
   end

   // conversion length; correction off halves remote time
   always @* begin
      conv_len = `SCS_CONV_CYC;
      if ((st_nxt == ST_REMOTE) && !series_resistance_fix_o) begin
         conv_len = `SCS_CONV_HALF_CYC;
      end
   end

   // idle length scales with rate code only; conversion fixed
   assign idle_len = (20'd8 - {17'd0, rate_r[2:0]}) * `SCS_IDLE_UNIT_CYC;

   // sequencer next state
   always @* begin
      st_nxt    = st_r;
      conv_load = 1'b0;
      idle_load = 1'b0;
      case (st_r)
         ST_IDLE: begin
            if (!stop_measure || oneshot_r) begin
               if (local_channel_on) begin
                  st_nxt = ST_LOCAL;
               end else if (remote_on) begin
                  st_nxt = ST_REMOTE;
               end else begin
                  st_nxt = ST_SHUT;
               end
            end
         end
         ST_LOCAL: begin
            if (conv_done) begin
               st_nxt = remote_on ? ST_REMOTE : ST_SHUT;
            end
         end
         ST_REMOTE: begin
            if (conv_done) begin
               st_nxt = ST_SHUT;
            end
         end
         ST_SHUT: begin
            // a one-shot or a stop ends here instead of delaying
            st_nxt = stop_measure ? ST_IDLE : ST_DELAY;
         end
         ST_DELAY: begin
            if (idle_done) begin
               st_nxt = ST_IDLE;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      // stop bit aborts a continuous cycle at once
      if (stop_measure && !oneshot_r && st_r == ST_DELAY) begin
         st_nxt = ST_IDLE;
      end
      // a running conversion is dropped too; its result is posted only if the stop lands in its last cycle
      if (stop_rise && (st_r == ST_LOCAL || st_r == ST_REMOTE)) begin
         st_nxt = ST_IDLE;
      end
      if ((st_nxt == ST_LOCAL || st_nxt == ST_REMOTE) && st_nxt != st_r) begin
         conv_load = 1'b1;
      end
      if (st_nxt == ST_DELAY && st_r != ST_DELAY) begin
         idle_load = 1'b1;
      end
   end

   // state register; stop bit delayed once to find its rising edge
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r     <= ST_IDLE;
         stop_q_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         stop_q_r <= stop_measure;
      end
   end

   // remembers which channel the finishing conversion belongs to
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ch_local_r    <= 1'b0;
         conv_local_o  <= 1'b0;
         conv_remote_o <= 1'b0;
      end else begin
         ch_local_r    <= (st_r == ST_LOCAL);
         conv_local_o  <= (st_nxt == ST_LOCAL);
         conv_remote_o <= (st_nxt == ST_REMOTE);
      end
   end

   scs_cnt u_conv (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .load_i    (conv_load),
      .clr_i     (stop_rise),
      .val_i     (conv_len),
      .done_o    (conv_done),
      .busy_o    (conv_busy)
   );

   scs_cnt u_idle (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .load_i    (idle_load),
      .clr_i     (stop_measure),
      .val_i     (idle_len),
      .done_o    (idle_done),
      .busy_o    (idle_busy)
   );

   // results only move at the end of a real conversion
   assign busy_o = (st_r == ST_LOCAL) || (st_r == ST_REMOTE);
   assign upd_o  = conv_done && busy_o;

   wire upd_local;
   wire upd_remote;
   assign upd_local  = upd_o && (st_r == ST_LOCAL);
   assign upd_remote = upd_o && (st_r == ST_REMOTE);

   scs_alarm u_lhi (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .upd_i     (upd_local),
      .temp_i    (local_temp_i),
      .lim_i     (local_hi_i),
      .hyst_i    (hyst_i),
      .hi_o      (local_over_high_flag_o)
   );

   scs_alarm u_rhi (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .upd_i     (upd_remote),
      .temp_i    (remote_temp_i),
      .lim_i     (remote_hi_i),
      .hyst_i    (hyst_i),
      .hi_o      (remote_over_high_flag_o)
   );

   // alert latch: set wins over the alert response clear
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         alert_r <= 1'b0;
      end else if (fault_i) begin
         alert_r <= 1'b1;
      end else if (ara_i) begin
         alert_r <= 1'b0;
      end
   end

   // pin is open drain: enable low pulls it low
   wire pin_low;
   assign pin_low = pin_function_select ?
                    (local_over_high_flag_o || remote_over_high_flag_o) :
                    (alert_r && !cfg1_r[`SCS_C1_MASK]);
   assign shared_alarm_pin_o    = 1'b0;
   assign shared_alarm_pin_oe_o = !pin_low;

   // ch_local_r and idle_busy kept for observation of sequence phase
   wire unused_ok;
   assign unused_ok = ch_local_r & idle_busy & conv_busy;
endmodule // scs_seq

// File: verif/scs_seq_assertions.sv
`timescale 1ns/100ps
module scs_seq_chk (
   input wire       clk_sys_i,               // system clock
   input wire       rst_b_i,                 // async reset, active low
   input wire       wr_i,                    // write strobe
   input wire [7:0] ptr_i,                   // register pointer
   input wire [7:0] wdata_i,                 // write data
   input wire [7:0] rdata_o,                 // read data
   input wire       ara_i,                   // alert response done
   input wire       fault_i,                 // limit fault
   input wire       conv_local_o,            // local conversion
   input wire       conv_remote_o,           // remote conversion
   input wire       busy_o,                  // converter busy
   input wire       upd_o,                   // result update
   input wire       local_over_high_flag_o,  // local over-high
   input wire       remote_over_high_flag_o, // remote over-high
   input wire       shared_alarm_pin_oe_o    // low drives the pin
);
   reg  [7:0] c1_r;
   reg  [7:0] c2_r;
   reg        c1_q_r;
   wire       ab_w  = c1_r[6] && !c1_q_r;
   wire       alm_w = !c1_r[5] && !c1_r[7];
   wire       hot_w = local_over_high_flag_o || remote_over_high_flag_o;
   wire       os_w  = wr_i && ptr_i == 8'h0f;
   // host-written config, so properties know the mode without peeking inside
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         c1_r <= 8'h00;
         c2_r <= 8'h1c;
      end else if (wr_i && ptr_i == 8'h09) begin
         c1_r <= wdata_i & 8'he4;
      end else if (wr_i && ptr_i == 8'h1a) begin
         c2_r <= wdata_i & 8'h1c;
      end
   end
   // delayed stop bit marks the cycle in which a stop aborts a conversion
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         c1_q_r <= 1'b0;
      end else begin
         c1_q_r <= c1_r[6];
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // readback is registered, so it is compared with the host-written config of the cycle before
   property p_cfg1_rd; ptr_i == 8'h03 |=> rdata_o == $past(c1_r); endproperty
   a_cfg1_rd: assert property (p_cfg1_rd) else $error("primary config readback");
   // a stop aborts the conversion, so an aborted run is not held to the length
   property p_conv_time; disable iff (!rst_b_i || ab_w)
      $rose(conv_local_o) && !ab_w |-> ##[198:200] upd_o; endproperty
   a_conv_time: assert property (p_conv_time) else $error("local conversion length");
   property p_order; $fell(conv_local_o) && c2_r[4] && $past(c2_r[4]) && !$past(ab_w)
      |-> ##[0:1] conv_remote_o; endproperty
   a_order: assert property (p_order) else $error("remote does not follow local");
   property p_skip_local; !c2_r[3] && !$past(c2_r[3]) |-> !$rose(conv_local_o); endproperty
   a_skip_local: assert property (p_skip_local) else $error("disabled local ran");
   property p_quiet; c1_r[6] && $past(c1_r[6]) && !busy_o && !os_w && !$past(os_w)
      |=> !busy_o && !upd_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("conversion in shutdown");
   property p_oneshot; c1_r[6] && $past(c1_r[6]) && !busy_o && !$past(busy_o)
      && c2_r[4:3] != 2'b00 && os_w |-> ##2 busy_o; endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot did not start");
   property p_stop; $rose(c1_r[6]) |=> !busy_o; endproperty
   a_stop: assert property (p_stop) else $error("stop did not halt conversion");
   property p_alert_set; alm_w && $past(alm_w) && fault_i && !wr_i
      |-> ##[1:2] !shared_alarm_pin_oe_o; endproperty
   a_alert_set: assert property (p_alert_set) else $error("alert not driven");
   property p_hold; alm_w && $past(alm_w) && !shared_alarm_pin_oe_o && !ara_i
      && !$past(ara_i) && !wr_i |=> !shared_alarm_pin_oe_o; endproperty
   a_hold: assert property (p_hold) else $error("alert released early");
   property p_overheat_output; c1_r[5] && $past(c1_r[5]) && hot_w
      |-> ##[0:1] !shared_alarm_pin_oe_o; endproperty
   a_overheat_output: assert property (p_overheat_output) else $error("overheat pin not low");
   c_oneshot: cover property (c1_r[6] && !busy_o && os_w);
   c_overheat_output: cover property (c1_r[5] && !shared_alarm_pin_oe_o);
   c_ack: cover property (alm_w && ara_i && !shared_alarm_pin_oe_o);
endmodule // scs_seq_chk

bind scs_seq scs_seq_chk u_chk (.clk_sys_i, .rst_b_i, .wr_i, .ptr_i, .wdata_i,
   .rdata_o, .ara_i, .fault_i, .conv_local_o, .conv_remote_o, .busy_o, .upd_o,
   .local_over_high_flag_o, .remote_over_high_flag_o, .shared_alarm_pin_oe_o);

// File: verif/scs_host.sv
`timescale 1ns/100ps
module scs_host (
   input  wire       clk_sys_i, // system clock
   input  wire [7:0] rdata_i,   // read data
   output reg        wr_o,      // write strobe
   output reg  [7:0] ptr_o,     // register pointer
   output reg  [7:0] wdata_o,   // write data
   output reg        ara_o      // alert response done
);
   initial begin
      wr_o = 1'b0;
      ptr_o = 8'h00;
      wdata_o = 8'h00;
      ara_o = 1'b0;
   end
   // one byte per strobe; data scrambled once released so stale data never helps
   task wr(input [7:0] p, input [7:0] d);
      @(posedge clk_sys_i);
      #1;
      ptr_o = p;
      wdata_o = (p == 8'h09) ? (d & 8'he4) : d;
      wr_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      wr_o = 1'b0;
      wdata_o = ~wdata_o;
   endtask
   // read answer is registered: the next edge loads it, taken just after
   task rd(input [7:0] p, output [7:0] d);
      @(posedge clk_sys_i);
      #1;
      ptr_o = p;
      @(posedge clk_sys_i);
      #1;
      d = rdata_i;
   endtask
   // alert response transaction, one cycle
   task ack;
      @(posedge clk_sys_i);
      #1;
      ara_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      ara_o = 1'b0;
   endtask
endmodule // scs_host

// File: verif/testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   reg        clk_sys_i, rst_b_i, fault_i;
   reg  [7:0] local_temp_i, remote_temp_i, local_hi_i, remote_hi_i, hyst_i;
   wire       wr_i, ara_i, conv_local_o, conv_remote_o, busy_o, upd_o, ext_range_o;
   wire       series_resistance_fix_o, local_over_high_flag_o, remote_over_high_flag_o;
   wire       shared_alarm_pin_o, shared_alarm_pin_oe_o;
   wire [7:0] ptr_i, wdata_i, rdata_o;
   int        tests_run, fails, cyc, n_upd, n_lr, n_rr, ll, rl, loc_len, rem_len;
   int        t0, per, p7, i;
   reg  [7:0] d, q;
   scs_seq DUT (.clk_sys_i, .rst_b_i, .wr_i, .ptr_i, .wdata_i, .rdata_o, .ara_i,
      .local_temp_i, .remote_temp_i, .local_hi_i, .remote_hi_i, .hyst_i, .fault_i,
      .conv_local_o, .conv_remote_o, .busy_o, .upd_o, .ext_range_o,
      .series_resistance_fix_o, .local_over_high_flag_o, .remote_over_high_flag_o,
      .shared_alarm_pin_o, .shared_alarm_pin_oe_o);
   scs_host h (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .wr_o(wr_i), .ptr_o(ptr_i),
      .wdata_o(wdata_i), .ara_o(ara_i));
   function int idle(input [7:0] r);
      return (8 - r[2:0]) * 100;
   endfunction
   task tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task pulse_fault;
      fault_i = 1'b1;
      tick(1);
      fault_i = 1'b0;
      tick(4);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   // conversion lengths, period and starts; also cuts a hang short
   always @(posedge clk_sys_i) begin
      cyc++;
      if (upd_o === 1'b1)
         n_upd++;
      if (conv_local_o === 1'b1 && ll == 0) begin
         n_lr++;
         per = cyc - t0;
         t0 = cyc;
      end
      if (conv_remote_o === 1'b1 && rl == 0)
         n_rr++;
      if (conv_local_o === 1'b1)
         ll++;
      else if (ll != 0) begin
         loc_len = ll;
         ll = 0;
      end
      if (conv_remote_o === 1'b1)
         rl++;
      else if (rl != 0) begin
         rem_len = rl;
         rl = 0;
      end
      if (cyc == 25000) begin
         fails++;
         report_and_stop;
      end
   end
   initial begin
      rst_b_i = 1'b0;
      fault_i = 1'b0;
      {local_temp_i, remote_temp_i} = 16'h1010;
      {local_hi_i, remote_hi_i, hyst_i} = 24'h50500a;
      void'($urandom(16));
      tick(4);
      rst_b_i = 1'b1;
      h.rd(8'h03, q);
      `CHK(q, 8'h00)
      h.rd(8'h1a, q);
      `CHK(q, 8'h1c)
      h.rd(8'h09, q);
      `CHK(q, 8'h00)
      $display("test reset_values done");
      for (i = 0; i < 6; i++) begin
         d = $urandom;
         {local_temp_i, remote_temp_i} = $urandom;
         h.wr(8'h09, d);
         h.rd(8'h03, q);
         `CHK(q, d & 8'he4)
         `CHK(ext_range_o, d[2])
         h.wr(8'h1a, d);
         h.rd(8'h1a, q);
         `CHK(q, d & 8'h1c)
         `CHK(series_resistance_fix_o, d[2])
      end
      {local_temp_i, remote_temp_i} = 16'h1010;
      h.wr(8'h09, 8'h00);
      h.wr(8'h1a, 8'h1c);
      h.wr(8'h0a, 8'h07);
      $display("test register_rw done");
      tick(1100);
      p7 = per;
      `CHK(loc_len, 200)
      `CHK(rem_len, 200)
      h.wr(8'h1a, 8'h18);
      tick(1100);
      `CHK(rem_len, 100)
      h.wr(8'h1a, 8'h1c);
      d = $urandom_range(0, 6);
      h.wr(8'h0a, d);
      h.rd(8'h04, q);
      `CHK(q, d)
      tick(2500);
      `CHK(per - p7, idle(d) - idle(8'h07))
      `CHK(loc_len, 200)
      h.wr(8'h0a, 8'h07);
      $display("test timing done");
      h.wr(8'h1a, 8'h14);
      tick(2);
      n_lr = 0;
      n_rr = 0;
      tick(1100);
      `CHK(n_lr, 0)
      `CHK(n_rr > 0, 1'b1)
      h.wr(8'h1a, 8'h0c);
      tick(600);
      n_lr = 0;
      n_rr = 0;
      tick(1100);
      `CHK(n_rr, 0)
      `CHK(n_lr > 0, 1'b1)
      h.wr(8'h1a, 8'h1c);
      $display("test channel_skip done");
      h.wr(8'h09, 8'h40);
      tick(600);
      `CHK(busy_o, 1'b0)
      n_upd = 0;
      tick(600);
      `CHK(n_upd, 0)
      h.wr(8'h0f, 8'h00);
      tick(1000);
      `CHK(n_upd, 2)
      `CHK(busy_o, 1'b0)
      h.wr(8'h09, 8'h00);
      tick(20);
      `CHK(busy_o, 1'b1)
      h.wr(8'h09, 8'h40);
      tick(1);
      `CHK(busy_o, 1'b0)
      h.wr(8'h09, 8'h00);
      $display("test shutdown done");
      pulse_fault;
      tick(50);
      `CHK(shared_alarm_pin_oe_o, 1'b0)
      h.ack;
      tick(2);
      `CHK(shared_alarm_pin_oe_o, 1'b1)
      h.wr(8'h09, 8'h80);
      pulse_fault;
      `CHK(shared_alarm_pin_oe_o, 1'b1)
      h.wr(8'h09, 8'h00);
      tick(2);
      `CHK(shared_alarm_pin_oe_o, 1'b0)
      h.ack;
      h.wr(8'h09, 8'ha0);
      remote_temp_i = 8'h80;
      tick(1100);
      `CHK(shared_alarm_pin_oe_o, 1'b0)
      `CHK(shared_alarm_pin_o, 1'b0)
      remote_temp_i = 8'h4a;
      tick(1100);
      `CHK(remote_over_high_flag_o, 1'b1)
      remote_temp_i = 8'h40;
      tick(1100);
      `CHK(remote_over_high_flag_o, 1'b0)
      `CHK(shared_alarm_pin_oe_o, 1'b1)
      $display("test alarm_pin done");
      report_and_stop;
   end
endmodule // testbench
